// ---- sto_timer_regs.svh ----
// Purpose: Register map, field positions, reset values and timing counts of the timer block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: Bits above each field read as zero
`ifndef STO_TIMER_REGS_SVH
`define STO_TIMER_REGS_SVH

`define STO_ADDR_CTRL0 4'h0
`define STO_ADDR_CTRL1 4'h1
`define STO_ADDR_CMPA 4'h2
`define STO_ADDR_CMPP 4'h3
`define STO_ADDR_FLAGS 4'h4
`define STO_ADDR_COUNT 4'h5

`define STO_C0_PAUSE 7
`define STO_C0_CKSEL_HI 6
`define STO_C0_CKSEL_LO 4
`define STO_C0_ON 3
`define STO_C1_MODE_HI 7
`define STO_C1_MODE_LO 6
`define STO_C1_IO_HI 5
`define STO_C1_IO_LO 4
`define STO_C1_OC 3
`define STO_C1_POL 2
`define STO_C1_DPX 1
`define STO_C1_CCLR 0
`define STO_FL_A 0
`define STO_FL_P 1

`define STO_RST_CTRL 8'h00
`define STO_RST_CMPA 16'h0000
`define STO_RST_CMPP 8'h00

`define STO_RESP_OKAY 2'b00
`define STO_RESP_SLVERR 2'b10

// Subsidiary clock: 32768 Hz nominal derived from the 100 MHz clock
`define STO_CLK_HZ 100000000
`define STO_SUB_HZ 32768
`define STO_SUB_DIV (`STO_CLK_HZ / `STO_SUB_HZ)

`endif

// ---- sto_timer_pkg.sv ----
// Purpose: Types shared by the timer block
// Assumes: Constants come from sto_timer_regs.svh
// Notes: Mode decode is done once in the top module
package sto_timer_pkg;

  typedef enum logic [1:0] {
    STO_MODE_CMP,
    STO_MODE_UNDEF,
    STO_MODE_PWM,
    STO_MODE_TC
  } sto_mode_e;

  typedef struct packed {
    logic pause;
    logic [2:0] clk_sel;
    logic on;
  } sto_ctrl0_s;

  typedef struct packed {
    logic [1:0] mode_sel;
    logic [1:0] pin_action;
    logic initial_level;
    logic invert;
    logic swap;
    logic clear_sel;
  } sto_ctrl1_s;

endpackage : sto_timer_pkg

// ---- sto_timer_top.sv ----
// Purpose: 16-bit count-up timer with compare, timer/counter, PWM and single-pulse modes
// Assumes: ref_clk 100 MHz, high-speed clock equals ref_clk, pins synchronous to ref_clk
// Notes: Registers reached over AXI4-Lite; see sto_timer_regs.svh for the map
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "sto_timer_regs.svh"

module sto_timer_top
  import sto_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_pin_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sto_ctrl0_s ctrl0_ff;
  sto_ctrl1_s ctrl1_ff;
  logic [15:0] compare_a_value_ff;
  logic [7:0] compare_p_value_ff;
  logic compare_a_flag_ff;
  logic compare_p_flag_ff;
  logic [15:0] count_ff;
  logic on_d_ff;
  logic ext_d_ff;
  logic [5:0] pre_ff;
  logic [11:0] sub_ff;
  logic pin_lvl_ff;

  logic aw_held_ff;
  logic w_held_ff;
  logic [3:0] aw_idx_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  sto_mode_e mode;
  logic wr_go;
  logic wr_ctrl0;
  logic on_rise;
  logic ext_rise;
  logic ext_fall;
  logic ext_trig;
  logic tick;
  logic run;
  logic [15:0] nxt_count;
  logic [15:0] inc_count;
  logic match_a;
  logic match_p;
  logic pwm_mode;
  logic pulse_mode;
  logic set_a;
  logic set_p;
  logic clr_cnt;
  logic [16:0] period_val;
  logic [16:0] duty_val;
  logic pwm_active;
  logic nxt_pin_lvl;
  logic nxt_pin_out;
  logic nxt_pin_oe;
  logic [3:0] ar_idx;
  logic [31:0] nxt_rdata;
  logic nxt_rerr;

  localparam logic [11:0] SUB_LAST = 12'(`STO_SUB_DIV - 1);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl1_ff.mode_sel)
      2'b00: mode = STO_MODE_CMP;
      2'b01: mode = STO_MODE_UNDEF;
      2'b10: mode = STO_MODE_PWM;
      2'b11: mode = STO_MODE_TC;
    endcase
  end

  assign pwm_mode = (mode == STO_MODE_PWM) && (ctrl1_ff.pin_action != 2'b11);
  assign pulse_mode = (mode == STO_MODE_PWM) && (ctrl1_ff.pin_action == 2'b11);

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_ctrl0 = wr_go && (aw_idx_ff == `STO_ADDR_CTRL0) && wstrb_ff[0];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      aw_idx_ff <= 4'h0;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_idx_ff <= (s_axi_awaddr[31:6] == 26'h0) ? s_axi_awaddr[5:2] : 4'hf;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_bvalid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_ff && !s_axi_bvalid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `STO_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_idx_ff > `STO_ADDR_COUNT) ? `STO_RESP_SLVERR : `STO_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Software write wins over hardware set and clear of the on bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl0_ff <= 5'(`STO_RST_CTRL);
    end else if (wr_ctrl0) begin
      ctrl0_ff.pause <= wdata_ff[`STO_C0_PAUSE];
      ctrl0_ff.clk_sel <= wdata_ff[`STO_C0_CKSEL_HI:`STO_C0_CKSEL_LO];
      ctrl0_ff.on <= wdata_ff[`STO_C0_ON];
    end else if (pulse_mode && ext_trig && !ctrl0_ff.on) begin
      ctrl0_ff.on <= 1'b1;
    end else if (pulse_mode && match_a) begin
      ctrl0_ff.on <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl1_ff <= `STO_RST_CTRL;
    end else if (wr_go && (aw_idx_ff == `STO_ADDR_CTRL1) && wstrb_ff[0]) begin
      ctrl1_ff <= wdata_ff[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      compare_a_value_ff <= `STO_RST_CMPA;
    end else if (wr_go && (aw_idx_ff == `STO_ADDR_CMPA)) begin
      if (wstrb_ff[0]) begin
        compare_a_value_ff[7:0] <= wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        compare_a_value_ff[15:8] <= wdata_ff[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      compare_p_value_ff <= `STO_RST_CMPP;
    end else if (wr_go && (aw_idx_ff == `STO_ADDR_CMPP) && wstrb_ff[0]) begin
      compare_p_value_ff <= wdata_ff[7:0];
    end
  end

  // Sticky flags, write one to clear; a new match wins over the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      compare_a_flag_ff <= 1'b0;
      compare_p_flag_ff <= 1'b0;
    end else begin
      if (set_a) begin
        compare_a_flag_ff <= 1'b1;
      end else if (wr_go && (aw_idx_ff == `STO_ADDR_FLAGS) && wstrb_ff[0]
                   && wdata_ff[`STO_FL_A]) begin
        compare_a_flag_ff <= 1'b0;
      end
      if (set_p) begin
        compare_p_flag_ff <= 1'b1;
      end else if (wr_go && (aw_idx_ff == `STO_ADDR_FLAGS) && wstrb_ff[0]
                   && wdata_ff[`STO_FL_P]) begin
        compare_p_flag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_ff <= 6'h00;
      sub_ff <= 12'h000;
      ext_d_ff <= 1'b0;
      on_d_ff <= 1'b0;
    end else begin
      pre_ff <= pre_ff + 6'h01;
      sub_ff <= (sub_ff == SUB_LAST) ? 12'h000 : sub_ff + 12'h001;
      ext_d_ff <= external_clock_pin;
      on_d_ff <= ctrl0_ff.on;
    end
  end

  assign ext_rise = external_clock_pin && !ext_d_ff;
  assign ext_fall = !external_clock_pin && ext_d_ff;
  assign ext_trig = (ctrl0_ff.clk_sel == 3'b111) ? ext_fall : ext_rise;
  assign on_rise = ctrl0_ff.on && !on_d_ff;

  always_comb begin
    unique case (ctrl0_ff.clk_sel)
      3'b000: tick = (pre_ff[1:0] == 2'h3);
      3'b001: tick = 1'b1;
      3'b010: tick = (pre_ff[3:0] == 4'hf);
      3'b011: tick = (pre_ff == 6'h3f);
      3'b100: tick = (sub_ff == SUB_LAST);
      3'b101: tick = (sub_ff == SUB_LAST);
      3'b110: tick = ext_rise;
      3'b111: tick = ext_fall;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter and comparators
  // ----------------------------------------------------------------
  assign run = ctrl0_ff.on && on_d_ff && !ctrl0_ff.pause && tick;
  assign inc_count = count_ff + 16'h0001;
  assign match_a = run && (compare_a_value_ff != 16'h0000)
                   && (inc_count == compare_a_value_ff);
  assign match_p = run && (inc_count[7:0] == 8'h00)
                   && (inc_count[15:8] == compare_p_value_ff);

  always_comb begin
    set_a = 1'b0;
    set_p = 1'b0;
    clr_cnt = 1'b0;
    if (pulse_mode) begin
      set_a = match_a;
    end else if (pwm_mode) begin
      set_a = match_a;
      set_p = match_p;
      clr_cnt = ctrl1_ff.swap ? match_a : match_p;
    end else if (ctrl1_ff.clear_sel) begin
      set_a = match_a;
      clr_cnt = match_a;
    end else begin
      set_a = match_a;
      set_p = match_p;
      clr_cnt = match_p;
    end
  end

  always_comb begin
    if (on_rise) begin
      nxt_count = 16'h0000;
    end else if (!run) begin
      nxt_count = count_ff;
    end else if (clr_cnt) begin
      nxt_count = 16'h0000;
    end else begin
      nxt_count = inc_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_ff <= 16'h0000;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ----------------------------------------------------------------
  // PWM waveform
  // ----------------------------------------------------------------
  always_comb begin
    if (ctrl1_ff.swap) begin
      period_val = (compare_a_value_ff == 16'h0000) ? 17'h10000
                   : {1'b0, compare_a_value_ff};
      duty_val = (compare_p_value_ff == 8'h00) ? 17'h10000
                 : {1'b0, compare_p_value_ff, 8'h00};
    end else begin
      period_val = (compare_p_value_ff == 8'h00) ? 17'h10000
                   : {1'b0, compare_p_value_ff, 8'h00};
      duty_val = {1'b0, compare_a_value_ff};
    end
  end

  assign pwm_active = (duty_val >= period_val) || ({1'b0, nxt_count} < duty_val);

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pin_lvl = pin_lvl_ff;
    if (on_rise) begin
      nxt_pin_lvl = ctrl1_ff.initial_level;
    end else if (set_a && (mode == STO_MODE_CMP)) begin
      unique case (ctrl1_ff.pin_action)
        2'b00: nxt_pin_lvl = pin_lvl_ff;
        2'b01: nxt_pin_lvl = 1'b0;
        2'b10: nxt_pin_lvl = 1'b1;
        2'b11: nxt_pin_lvl = !pin_lvl_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_lvl_ff <= 1'b0;
    end else begin
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  always_comb begin
    nxt_pin_oe = 1'b1;
    nxt_pin_out = 1'b0;
    if (mode == STO_MODE_CMP) begin
      nxt_pin_out = nxt_pin_lvl;
    end else if (pulse_mode) begin
      nxt_pin_out = (nxt_count != 16'h0000 || on_rise) && ctrl0_ff.on
                    && !(match_a) ? ctrl1_ff.initial_level
                    : !ctrl1_ff.initial_level;
    end else if (pwm_mode) begin
      unique case (ctrl1_ff.pin_action)
        2'b00: nxt_pin_out = !ctrl1_ff.initial_level;
        2'b01: nxt_pin_out = ctrl1_ff.initial_level;
        default: nxt_pin_out = (pwm_active && ctrl0_ff.on) ? ctrl1_ff.initial_level
                               : !ctrl1_ff.initial_level;
      endcase
    end else begin
      nxt_pin_oe = 1'b0;
    end
    nxt_pin_out = nxt_pin_oe && (nxt_pin_out ^ ctrl1_ff.invert);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_output_pin <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else begin
      timer_output_pin <= nxt_pin_out;
      timer_output_pin_oe <= nxt_pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign ar_idx = (s_axi_araddr[31:6] == 26'h0) ? s_axi_araddr[5:2] : 4'hf;

  always_comb begin
    nxt_rdata = 32'h0;
    nxt_rerr = 1'b0;
    case (ar_idx)
      `STO_ADDR_CTRL0: nxt_rdata = {24'h0, ctrl0_ff, 3'b000};
      `STO_ADDR_CTRL1: nxt_rdata = {24'h0, ctrl1_ff};
      `STO_ADDR_CMPA: nxt_rdata = {16'h0, compare_a_value_ff};
      `STO_ADDR_CMPP: nxt_rdata = {24'h0, compare_p_value_ff};
      `STO_ADDR_FLAGS: nxt_rdata = {30'h0, compare_p_flag_ff, compare_a_flag_ff};
      `STO_ADDR_COUNT: nxt_rdata = {16'h0, count_ff};
      default: nxt_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `STO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rerr ? `STO_RESP_SLVERR : `STO_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sto_timer_top

// ---- sto_timer_props.sv ----
// Purpose: Port-level assertions for the timer block
// Assumes: Write address and data are offered together
// Notes: Control writes are shadowed from the register bus
`timescale 1ns/10ps
`include "sto_timer_regs.svh"
module sto_timer_props
  import sto_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe
);
  // ----------------
  // Control shadows
  // ----------------
  logic wr_go;
  logic [7:0] c0_ff;
  logic [7:0] c1_ff;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      c0_ff <= 8'h0;
    end else if (wr_go && s_axi_awaddr[7:0] == 8'h0) begin
      c0_ff <= s_axi_wdata[7:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      c1_ff <= 8'h0;
    end else if (wr_go && s_axi_awaddr[7:0] == 8'h4) begin
      c1_ff <= s_axi_wdata[7:0];
    end
  end
  // ----------------
  // Assertions
  // ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence on_rise_s;
    $rose(c0_ff[3]) && c1_ff[7:6] == 2'h0 && !c1_ff[2];
  endsequence
  sequence tc_mode_s;
    (c1_ff[7:6] == 2'h3) [*4];
  endsequence
  wr_answer_a: assert property (wr_go |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  rd_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > 8'h14
    |=> s_axi_rresp == `STO_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  tc_pin_off_a: assert property (tc_mode_s |-> !timer_output_pin_oe && !timer_output_pin)
    else $error("pin driven in timer mode");
  pwm_drive_a: assert property ((c1_ff[7:6] == 2'h2) [*4] |-> timer_output_pin_oe)
    else $error("pin not driven in pulse mode");
  init_level_a: assert property (on_rise_s |-> ##[1:3] timer_output_pin == c1_ff[3])
    else $error("pin not set to initial level");
endmodule : sto_timer_props

// ---- tb_standard_timer_operating_modes.sv ----
// Purpose: Self-checking bench for the timer block
// Assumes: 100 MHz ref_clk, registers reached over AXI4-Lite
// Notes: Pin duty is measured by sampling every cycle
`timescale 1ns/10ps
`include "sto_timer_regs.svh"
module tb_standard_timer_operating_modes
  import sto_timer_pkg::*;
;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0, ext = 1'h0;
  logic aw_r, w_r, b_v, ar_r, r_v, pin, oe;
  logic [1:0] bresp, rresp, last_b;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] pw_c1 [7] = '{8'ha8, 8'hac, 8'ha9, 8'ha8, 8'haa, 8'h98, 8'h88};
  logic [15:0] pw_a [7] = '{16'h40, 16'h40, 16'h40, 16'h200, 16'h300, 16'h40, 16'h40};
  int pw_n [7] = '{256, 256, 256, 256, 768, 256, 256};
  int pw_h [7] = '{64, 192, 64, 256, 256, 256, 0};
  logic [1:0] pw_f [7] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3};
  logic [7:0] ck_c0 [3] = '{8'h08, 8'h28, 8'h38};

  sto_timer_top dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .external_clock_pin(ext), .timer_output_pin(pin), .timer_output_pin_oe(oe)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------
  // Bus and check tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'h0;
    awaddr <= {24'h0, a};
    wdata <= d;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_r <= 1'h1;
    while (!done) begin
      @(posedge ref_clk);
      if (aw_r) aw_v <= 1'h0;
      if (w_r) w_v <= 1'h0;
      if (b_v === 1'h1) begin
        done = 1'h1;
        last_b = bresp;
        b_r <= 1'h0;
      end
    end
    @(posedge ref_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    logic done;
    done = 1'h0;
    araddr <= {24'h0, a};
    ar_v <= 1'h1;
    r_r <= 1'h1;
    while (!done) begin
      @(posedge ref_clk);
      if (ar_r) ar_v <= 1'h0;
      if (r_v === 1'h1) begin
        done = 1'h1;
        d = rdata;
        s = rresp;
        r_r <= 1'h0;
      end
    end
    @(posedge ref_clk);
  endtask : axi_rd

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] s;
    axi_rd(a, d, s);
    chk(d & m, e);
  endtask : rdm

  task automatic wait_flag(input int b);
    logic [31:0] d;
    logic [1:0] s;
    d = 32'h0;
    while (d[b] !== 1'h1) axi_rd(8'h10, d, s);
  endtask : wait_flag

  // Stop, load compares and mode, clear flags, then write the given control 0 value
  task automatic cfg(input sto_ctrl1_s c1, input logic [15:0] a, input logic [7:0] p,
                     input logic [7:0] c0);
    axi_wr(8'h00, 32'h0);
    axi_wr(8'h08, {16'h0, a});
    axi_wr(8'h0c, {24'h0, p});
    axi_wr(8'h04, {24'h0, c1});
    axi_wr(8'h10, 32'h3);
    axi_wr(8'h00, {24'h0, c0});
  endtask : cfg

  task automatic hi_cnt(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (pin === 1'h1) h++;
    end
  endtask : hi_cnt

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ----------------
  // Tests
  // ----------------
  initial begin
    logic [31:0] d, c;
    logic [1:0] s;
    int h;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) rdm(8'(4 * i), 32'hffffffff, 32'h0);
    axi_rd(8'h18, d, s);
    chk(s, `STO_RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(8'h18, 32'h5);
    chk(last_b, `STO_RESP_SLVERR);
    axi_wr(8'h14, 32'h1234);
    rdm(8'h14, 32'hffff, 32'h0);
    // Compare mode, clear on A with every pin action, then clear on P; timer/counter mode
    for (int i = 0; i < 4; i++) begin
      cfg({2'h0, 2'(i), i < 2, 3'h1}, 16'h0300, 8'h01, 8'h18);
      chk(pin, i < 2);
      chk(oe, 1'h1);
      wait_flag(0);
      rdm(8'h10, 32'h3, 32'h1);
      chk(pin, i != 1);
    end
    cfg(8'h30, 16'h0300, 8'h01, 8'h18);
    wait_flag(1);
    rdm(8'h10, 32'h3, 32'h2);
    rdm(8'h14, 32'hff00, 32'h0);
    chk(pin, 1'h0);
    cfg(8'hc0, 16'h0080, 8'h01, 8'h18);
    wait_flag(1);
    rdm(8'h10, 32'h3, 32'h3);
    chk(oe, 1'h0);
    // Pause, stop and restart
    cfg(8'hc1, 16'h0000, 8'h00, 8'h18);
    axi_wr(8'h00, 32'h98);
    axi_rd(8'h14, c, s);
    repeat (40) @(posedge ref_clk);
    rdm(8'h14, 32'hffff, c);
    axi_wr(8'h00, 32'h18);
    repeat (40) @(posedge ref_clk);
    axi_rd(8'h14, d, s);
    chk(d > c + 32'h28, 1'h1);
    axi_wr(8'h00, 32'h10);
    axi_rd(8'h14, c, s);
    repeat (40) @(posedge ref_clk);
    rdm(8'h14, 32'hffff, c);
    rdm(8'h10, 32'h3, 32'h0);
    axi_wr(8'h00, 32'h18);
    rdm(8'h14, 32'hfff0, 32'h0);
    // External pin as counter clock, both edges
    for (int j = 0; j < 2; j++) begin
      cfg(8'hc0, 16'h0000, 8'h00, 8'h68 + 8'(16 * j));
      repeat (5) begin
        ext <= 1'h1;
        repeat (4) @(posedge ref_clk);
        ext <= 1'h0;
        repeat (4) @(posedge ref_clk);
      end
      rdm(8'h14, 32'hffff, 32'h5);
    end
    // Divided system clocks: 4, 16 and 64 ref_clk cycles per tick
    for (int m = 0; m < 3; m++) begin
      cfg(8'hc0, 16'h0000, 8'h00, ck_c0[m]);
      repeat (256) @(posedge ref_clk);
      axi_rd(8'h14, d, s);
      chk(d + 32'h1 >= 32'(64 >> (2 * m)) && d <= 32'((64 >> (2 * m)) + 1), 1'h1);
    end
    // PWM shapes
    for (int k = 0; k < 7; k++) begin
      cfg(pw_c1[k], pw_a[k], 8'h01, 8'h18);
      repeat (pw_n[k]) @(posedge ref_clk);
      hi_cnt(pw_n[k], h);
      chk(h, pw_h[k]);
      rdm(8'h10, 32'h3, {30'h0, pw_f[k]});
    end
    // Single pulse by software, then by the external pin
    cfg(8'hb8, 16'h0100, 8'h00, 8'h18);
    chk(pin, 1'h1);
    axi_wr(8'h00, 32'h10);
    chk(pin, 1'h0);
    cfg(8'hb8, 16'h0020, 8'h00, 8'h10);
    ext <= 1'h1;
    hi_cnt(100, h);
    ext <= 1'h0;
    chk(h >= 31 && h <= 34, 1'h1);
    rdm(8'h00, 32'h8, 32'h0);
    rdm(8'h10, 32'h1, 32'h1);
    rdm(8'h14, 32'hffff, 32'h20);
    chk(pin, 1'h0);
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule : tb_standard_timer_operating_modes

bind sto_timer_top sto_timer_props chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .timer_output_pin(timer_output_pin), .timer_output_pin_oe(timer_output_pin_oe)
);
